// [pcg_params.svh]
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH
// register byte offsets
`define PCG_OFF_RUN_CFG 12'h060
`define PCG_OFF_RUN0 12'h100
`define PCG_OFF_RUN1 12'h104
`define PCG_OFF_SLP0 12'h110
`define PCG_OFF_SLP1 12'h114
`define PCG_OFF_DSL0 12'h120
`define PCG_OFF_DSL1 12'h124
`define PCG_OFF_INT_STAT 12'h180
`define PCG_OFF_INT_MASK 12'h184
// field positions
`define PCG_ADC_LSB 8
`define PCG_HIB_BIT 6
`define PCG_WDT_BIT 3
`define PCG_CMP0_BIT 24
`define PCG_CMP1_BIT 25
`define PCG_CMP2_BIT 26
`define PCG_ACG_BIT 27
// writable bits per register
`define PCG_MASK_GATE0 32'h0000_0348
`define PCG_MASK_GATE1 32'h0700_0000
`define PCG_MASK_RUN_CFG 32'h0800_0000
`define PCG_MASK_INT 32'h0000_0003
// reset values
`define PCG_GATE_RST 32'h0000_0000
`define PCG_RUN_CFG_RST 32'h0000_0000
`define PCG_INT_RST 32'h0000_0000
// sample rate codes
`define PCG_ADC_125K 2'h0
`define PCG_ADC_250K 2'h1
// event bits of the status register
`define PCG_EVT_RD_FAULT 0
`define PCG_EVT_WR_FAULT 1
// axi responses
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2
`endif

// [pcg_pkg.sv]
package pcg_pkg;
  typedef enum logic [1:0] {PCG_MODE_RUN, PCG_MODE_SLEEP, PCG_MODE_DEEP} pcg_power_mode_t;
  typedef enum logic [3:0] {
    PCG_REG_NONE, PCG_REG_RUN_CFG, PCG_REG_RUN0, PCG_REG_RUN1, PCG_REG_SLP0,
    PCG_REG_SLP1, PCG_REG_DSL0, PCG_REG_DSL1, PCG_REG_INT_STAT, PCG_REG_INT_MASK
  } pcg_reg_t;
  // peripheral ids, also the bit index in the gate vector
  typedef enum logic [2:0] {
    PCG_P_WDT, PCG_P_HIB, PCG_P_CMP0, PCG_P_CMP1, PCG_P_CMP2
  } pcg_periph_t;
  typedef struct packed {
    logic valid;
    logic write;
    pcg_periph_t id;
  } pcg_periph_req_t;
  typedef struct packed {
    logic valid;
    logic fault;
  } pcg_periph_resp_t;
endpackage

// [pcg_clk_gate.sv]
`timescale 1ns/1ps
// glitch-free gate: enable latched while the clock is low
module pcg_clk_gate (
  // clock in
  input wire logic core_clk,
  input wire logic gate_en,
  // gated clock out
  output logic gated_clk
);
  logic en_lat;

  always_latch begin
    if (!core_clk) begin
      en_lat = gate_en;
    end
  end

  assign gated_clk = core_clk & en_lat;
endmodule

// [pcg_fault_chk.sv]
`timescale 1ns/1ps
// answers peripheral accesses, faulting those whose clock is off
module pcg_fault_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // access and gate state
  input wire pcg_pkg::pcg_periph_req_t periph_req,
  input wire logic [4:0] gate_en,
  // answer and events
  output pcg_pkg::pcg_periph_resp_t periph_resp,
  output logic rd_fault_evt,
  output logic wr_fault_evt
);
  import pcg_pkg::*;

  logic hit_off;

  assign hit_off = periph_req.valid && !gate_en[periph_req.id];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      periph_resp <= '0;
    end else begin
      periph_resp.valid <= periph_req.valid;
      periph_resp.fault <= hit_off; // R5
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_fault_evt <= 1'b0;
      wr_fault_evt <= 1'b0;
    end else begin
      rd_fault_evt <= hit_off && !periph_req.write;
      wr_fault_evt <= hit_off && periph_req.write;
    end
  end
endmodule

// [pcg_top.sv]
// Functional notes
// R1 - bits 9:8 pick adc rate: 0x1 is 250K, 0x0 is 125K samples/s
// R2 - the applied adc rate is clamped to the maximum allowed rate
// R3 - bit 6 set clocks the hibernation unit, clear stops it
// R4 - bit 3 set clocks the watchdog, clear stops it
// R5 - access to an unclocked peripheral is answered with a bus fault
// R6 - reserved bits, 15:10 among them, read zero and ignore writes
// R7 - all gate bits reset to zero, so every peripheral starts unclocked
// R8 - run, sleep and deep-sleep gate sets apply in their own power mode
// R9 - sleep and deep-sleep sets apply only while auto gating is enabled
// R10 - run register 1 bits 26,25,24 clock comparators 2,1,0
// R11 - run register 1 at 0x104 resets to zero; 31:27 and 23:20 read zero
// R12 - each peripheral clock passes a latch-based glitch-free gate
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "pcg_params.svh"
module pcg_top #(
  parameter int ADDR_W = 12,
  parameter logic [1:0] MAX_ADC_CODE = `PCG_ADC_250K
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // power state
  input wire pcg_pkg::pcg_power_mode_t power_mode,
  // peripheral access check
  input wire pcg_pkg::pcg_periph_req_t periph_req,
  output pcg_pkg::pcg_periph_resp_t periph_resp,
  // gated clocks and their enables
  output logic [4:0] periph_clk_en,
  output logic [4:0] periph_gclk,
  output logic [1:0] adc_rate_sel,
  // interrupt
  output logic irq
);
  import pcg_pkg::*;

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W must be 12 to 32");
  end
  if (MAX_ADC_CODE > `PCG_ADC_250K) begin : g_chk_adc
    $error("MAX_ADC_CODE above the fastest rate");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic pcg_reg_t decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] off;
    off = addr[11:0];
    if ((addr >> 12) != '0) begin
      decode = PCG_REG_NONE;
    end else begin
      case (off)
        `PCG_OFF_RUN_CFG: decode = PCG_REG_RUN_CFG;
        `PCG_OFF_RUN0: decode = PCG_REG_RUN0;
        `PCG_OFF_RUN1: decode = PCG_REG_RUN1;
        `PCG_OFF_SLP0: decode = PCG_REG_SLP0;
        `PCG_OFF_SLP1: decode = PCG_REG_SLP1;
        `PCG_OFF_DSL0: decode = PCG_REG_DSL0;
        `PCG_OFF_DSL1: decode = PCG_REG_DSL1;
        `PCG_OFF_INT_STAT: decode = PCG_REG_INT_STAT;
        `PCG_OFF_INT_MASK: decode = PCG_REG_INT_MASK;
        default: decode = PCG_REG_NONE;
      endcase
    end
  endfunction

  // byte-lane merge, only writable bits change
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~lane) | (data & lane);
  endfunction

  // register 0 write with the adc field held at or below the maximum
  function automatic logic [31:0] merge0(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] val;
    val = merge(old, data, strb, `PCG_MASK_GATE0);
    if (val[`PCG_ADC_LSB+:2] > MAX_ADC_CODE) begin
      val[`PCG_ADC_LSB+:2] = MAX_ADC_CODE; // R2
    end
    merge0 = val;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic aw_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic w_hold_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic rd_fire;
  pcg_reg_t wr_sel;
  pcg_reg_t rd_sel;
  logic [31:0] rd_mux;

  logic [31:0] run_clock_config_reg;
  logic [31:0] run_gate_ctrl_zero_reg;
  logic [31:0] run_gate_ctrl_one_reg;
  logic [31:0] sleep_gate_ctrl_zero_reg;
  logic [31:0] sleep_gate_ctrl_one_reg;
  logic [31:0] deep_sleep_gate_ctrl_zero_reg;
  logic [31:0] deep_sleep_gate_ctrl_one_reg;
  logic [31:0] int_stat_reg;
  logic [31:0] int_mask_reg;
  logic [31:0] int_stat_next;

  logic [31:0] sel_gate0;
  logic [31:0] sel_gate1;
  logic [4:0] gate_next;
  logic [4:0] gate_reg;
  logic [1:0] adc_rate_reg;
  logic rd_fault_evt;
  logic wr_fault_evt;

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_sel = decode(awaddr_reg);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `PCG_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == PCG_REG_NONE) ? `PCG_RESP_SLVERR : `PCG_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign s_axi_arready = !rvalid_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_sel = decode(s_axi_araddr);

  always_comb begin
    case (rd_sel)
      PCG_REG_RUN_CFG: rd_mux = run_clock_config_reg;
      PCG_REG_RUN0: rd_mux = run_gate_ctrl_zero_reg;
      PCG_REG_RUN1: rd_mux = run_gate_ctrl_one_reg;
      PCG_REG_SLP0: rd_mux = sleep_gate_ctrl_zero_reg;
      PCG_REG_SLP1: rd_mux = sleep_gate_ctrl_one_reg;
      PCG_REG_DSL0: rd_mux = deep_sleep_gate_ctrl_zero_reg;
      PCG_REG_DSL1: rd_mux = deep_sleep_gate_ctrl_one_reg;
      PCG_REG_INT_STAT: rd_mux = int_stat_reg;
      PCG_REG_INT_MASK: rd_mux = int_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `PCG_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux; // R6
      rresp_reg <= (rd_sel == PCG_REG_NONE) ? `PCG_RESP_SLVERR : `PCG_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      run_clock_config_reg <= `PCG_RUN_CFG_RST;
    end else if (wr_fire && wr_sel == PCG_REG_RUN_CFG) begin
      run_clock_config_reg <= merge(run_clock_config_reg, wdata_reg, wstrb_reg,
                                    `PCG_MASK_RUN_CFG);
    end
  end

  // run-mode gate set
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      run_gate_ctrl_zero_reg <= `PCG_GATE_RST; // R7
      run_gate_ctrl_one_reg <= `PCG_GATE_RST; // R11
    end else if (wr_fire && wr_sel == PCG_REG_RUN0) begin
      run_gate_ctrl_zero_reg <= merge0(run_gate_ctrl_zero_reg, wdata_reg, wstrb_reg);
    end else if (wr_fire && wr_sel == PCG_REG_RUN1) begin
      run_gate_ctrl_one_reg <= merge(run_gate_ctrl_one_reg, wdata_reg, wstrb_reg,
                                     `PCG_MASK_GATE1); // R11
    end
  end

  // sleep gate set
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sleep_gate_ctrl_zero_reg <= `PCG_GATE_RST; // R7
      sleep_gate_ctrl_one_reg <= `PCG_GATE_RST;
    end else if (wr_fire && wr_sel == PCG_REG_SLP0) begin
      sleep_gate_ctrl_zero_reg <= merge0(sleep_gate_ctrl_zero_reg, wdata_reg, wstrb_reg);
    end else if (wr_fire && wr_sel == PCG_REG_SLP1) begin
      sleep_gate_ctrl_one_reg <= merge(sleep_gate_ctrl_one_reg, wdata_reg, wstrb_reg,
                                       `PCG_MASK_GATE1);
    end
  end

  // deep-sleep gate set
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      deep_sleep_gate_ctrl_zero_reg <= `PCG_GATE_RST; // R7
      deep_sleep_gate_ctrl_one_reg <= `PCG_GATE_RST;
    end else if (wr_fire && wr_sel == PCG_REG_DSL0) begin
      deep_sleep_gate_ctrl_zero_reg <= merge0(deep_sleep_gate_ctrl_zero_reg, wdata_reg,
                                              wstrb_reg); // R6
    end else if (wr_fire && wr_sel == PCG_REG_DSL1) begin
      deep_sleep_gate_ctrl_one_reg <= merge(deep_sleep_gate_ctrl_one_reg, wdata_reg,
                                            wstrb_reg, `PCG_MASK_GATE1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gate set selection by power mode

  always_comb begin
    sel_gate0 = run_gate_ctrl_zero_reg;
    sel_gate1 = run_gate_ctrl_one_reg;
    if (run_clock_config_reg[`PCG_ACG_BIT]) begin // R9
      case (power_mode) // R8
        PCG_MODE_SLEEP: begin
          sel_gate0 = sleep_gate_ctrl_zero_reg;
          sel_gate1 = sleep_gate_ctrl_one_reg;
        end
        PCG_MODE_DEEP: begin
          sel_gate0 = deep_sleep_gate_ctrl_zero_reg;
          sel_gate1 = deep_sleep_gate_ctrl_one_reg;
        end
        default: begin
          sel_gate0 = run_gate_ctrl_zero_reg;
          sel_gate1 = run_gate_ctrl_one_reg;
        end
      endcase
    end
  end

  always_comb begin
    gate_next = 5'h00;
    gate_next[PCG_P_WDT] = sel_gate0[`PCG_WDT_BIT]; // R4
    gate_next[PCG_P_HIB] = sel_gate0[`PCG_HIB_BIT]; // R3
    gate_next[PCG_P_CMP0] = sel_gate1[`PCG_CMP0_BIT]; // R10
    gate_next[PCG_P_CMP1] = sel_gate1[`PCG_CMP1_BIT]; // R10
    gate_next[PCG_P_CMP2] = sel_gate1[`PCG_CMP2_BIT]; // R10
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gate_reg <= 5'h00;
      adc_rate_reg <= `PCG_ADC_125K;
    end else begin
      gate_reg <= gate_next;
      adc_rate_reg <= sel_gate0[`PCG_ADC_LSB+:2]; // R1
    end
  end

  assign periph_clk_en = gate_reg;
  assign adc_rate_sel = adc_rate_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock gates

  for (genvar i = 0; i < 5; i++) begin : g_gate
    pcg_clk_gate u_gate (
      .core_clk(core_clk),
      .gate_en(gate_reg[i]),
      .gated_clk(periph_gclk[i])
    ); // R12
  end

  ////////////////////////////////////////////////////////////////////////////////
  // peripheral access check

  pcg_fault_chk u_fault (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .periph_req(periph_req),
    .gate_en(gate_reg),
    .periph_resp(periph_resp),
    .rd_fault_evt(rd_fault_evt),
    .wr_fault_evt(wr_fault_evt)
  ); // R5

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  always_comb begin
    int_stat_next = int_stat_reg;
    if (rd_fire && rd_sel == PCG_REG_INT_STAT) begin
      int_stat_next = 32'h0000_0000;
    end
    if (rd_fault_evt) begin
      int_stat_next[`PCG_EVT_RD_FAULT] = 1'b1;
    end
    if (wr_fault_evt) begin
      int_stat_next[`PCG_EVT_WR_FAULT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      int_stat_reg <= `PCG_INT_RST;
    end else begin
      int_stat_reg <= int_stat_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      int_mask_reg <= `PCG_INT_RST;
    end else if (wr_fire && wr_sel == PCG_REG_INT_MASK) begin
      int_mask_reg <= merge(int_mask_reg, wdata_reg, wstrb_reg, `PCG_MASK_INT);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_next & int_mask_reg);
    end
  end

  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule

// [pcg_top_properties.sv]
`timescale 1ns/1ps
`include "pcg_params.svh"
module pcg_top_properties #(
  parameter int ADDR_W = 12,
  parameter logic [1:0] MAX_ADC_CODE = `PCG_ADC_250K
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // gating and probes
  input wire pcg_pkg::pcg_periph_req_t periph_req,
  input wire pcg_pkg::pcg_periph_resp_t periph_resp,
  input wire logic [4:0] periph_clk_en,
  input wire logic [1:0] adc_rate_sel,
  input wire logic irq
);
  import pcg_pkg::*;
  localparam logic [31:0] LIVE_BITS = `PCG_MASK_GATE0 | `PCG_MASK_GATE1 | `PCG_MASK_RUN_CFG
    | `PCG_MASK_INT;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_probe_answered: assert property (periph_req.valid |=> periph_resp.valid)
    else $error("probe not answered one cycle later");
  a_fault_gate_off: assert property (
    periph_req.valid && !periph_clk_en[periph_req.id] |=> periph_resp.fault)
    else $error("access to unclocked unit not faulted");
  a_gate_on_clean: assert property (
    periph_req.valid && periph_clk_en[periph_req.id] |=> !periph_resp.fault)
    else $error("access to clocked unit faulted");
  a_rate_clamped: assert property (adc_rate_sel <= MAX_ADC_CODE)
    else $error("applied sample rate above maximum");
  a_reset_cold: assert property (
    $rose(reset_n) |-> periph_clk_en == 5'h00 && adc_rate_sel == 2'h0 && !irq)
    else $error("outputs not cold after reset");
  a_reserved_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & ~LIVE_BITS) == 32'h0)
    else $error("reserved read bits not zero");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle later");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  c_fault_seen: cover property (periph_resp.valid && periph_resp.fault);
  c_irq_rise: cover property ($rose(irq));
  c_write_error: cover property (s_axi_bvalid && s_axi_bresp == `PCG_RESP_SLVERR);
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "pcg_params.svh"
module tb_top;
  import pcg_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
    logic [31:0] rdata;
    logic [4:0] en;
    logic [1:0] rate;
  } pcg_row_t;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  pcg_power_mode_t power_mode = PCG_MODE_RUN;
  pcg_periph_req_t periph_req = '0;
  pcg_periph_resp_t periph_resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, adc_rate_sel;
  logic [31:0] s_axi_rdata;
  logic [4:0] periph_clk_en, periph_gclk;
  int err_count = 0;
  int comparisons = 0;
  // en is {cmp2, cmp1, cmp0, hib, wdt}
  pcg_row_t rows [9] = '{
    '{12'h104, 32'hffff_ffff, 4'hf, 32'h0700_0000, 5'h1c, 2'h0},
    '{12'h100, 32'hffff_ffff, 4'hf, 32'h0000_0148, 5'h1f, 2'h1},
    '{12'h100, 32'h0000_0208, 4'hf, 32'h0000_0108, 5'h1d, 2'h1},
    '{12'h100, 32'h0000_0040, 4'hf, 32'h0000_0040, 5'h1e, 2'h0},
    '{12'h104, 32'h0200_0000, 4'hf, 32'h0200_0000, 5'h0a, 2'h0},
    '{12'h104, 32'hffff_ffff, 4'h7, 32'h0200_0000, 5'h0a, 2'h0},
    '{12'h120, 32'h0000_fe00, 4'hf, 32'h0000_0100, 5'h0a, 2'h0},
    '{12'h124, 32'h0500_0000, 4'hf, 32'h0500_0000, 5'h0a, 2'h0},
    '{12'h184, 32'hffff_ffff, 4'hf, 32'h0000_0003, 5'h0a, 2'h0}};

  pcg_top dut (
    .core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .power_mode(power_mode), .periph_req(periph_req), .periph_resp(periph_resp),
    .periph_clk_en(periph_clk_en), .periph_gclk(periph_gclk),
    .adc_rate_sel(adc_rate_sel), .irq(irq));

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_bits(input string nm, input logic [4:0] exp, input logic [4:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic ka, kw, ta, tw;
    ka = 1'b1;
    kw = 1'b1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (ka || kw) begin
      @(negedge core_clk);
      ta = ka && s_axi_awready;
      tw = kw && s_axi_wready;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      ka = ka && !ta;
      kw = kw && !tw;
    end
    do begin
      @(negedge core_clk);
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge core_clk);
    s_axi_bready <= 1'b1;
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!t) begin
      @(negedge core_clk);
      t = s_axi_arready;
      @(posedge core_clk);
    end
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge core_clk);
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 1'b1;
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic probe(input pcg_periph_t id, input logic wr, input logic exp);
    @(posedge core_clk);
    periph_req <= '{valid: 1'b1, write: wr, id: id};
    @(posedge core_clk);
    periph_req <= '0;
    @(negedge core_clk);
    chk_bits("probe valid", 5'h01, {4'h0, periph_resp.valid});
    chk_bits("probe fault", {4'h0, exp}, {4'h0, periph_resp.fault});
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
  endtask
  task automatic check_cold;
    logic [31:0] d;
    logic [1:0] r;
    chk_bits("cold clk en", 5'h00, periph_clk_en);
    chk_bits("cold irq", 5'h00, {4'h0, irq});
    axi_rd(`PCG_OFF_RUN1, d, r);
    chk_word("cold run1", `PCG_GATE_RST, d);
    axi_rd(`PCG_OFF_DSL0, d, r);
    chk_word("cold deep0", `PCG_GATE_RST, d);
  endtask
  task automatic set_mode(input pcg_power_mode_t m, input logic [4:0] en, input logic [1:0] rt);
    @(posedge core_clk);
    power_mode <= m;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk_bits("mode clk en", en, periph_clk_en);
    chk_bits("mode rate", {3'h0, rt}, {3'h0, adc_rate_sel});
    @(posedge core_clk);
    #1;
    chk_bits("gated clk", en, periph_gclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    err_count++;
    final_report();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    do_reset();
    check_cold();
    foreach (rows[i]) begin
      axi_wr(rows[i].addr, rows[i].wdata, rows[i].strb, r);
      chk_word("write resp", {30'h0, `PCG_RESP_OKAY}, {30'h0, r});
      axi_rd(rows[i].addr, d, r);
      @(negedge core_clk);
      chk_word("readback", rows[i].rdata, d);
      chk_bits("clk en", rows[i].en, periph_clk_en);
      chk_bits("adc rate", {3'h0, rows[i].rate}, {3'h0, adc_rate_sel});
    end
    probe(PCG_P_HIB, 1'b0, 1'b0);
    probe(PCG_P_CMP1, 1'b1, 1'b0);
    probe(PCG_P_WDT, 1'b0, 1'b1);
    probe(PCG_P_CMP2, 1'b1, 1'b1);
    @(negedge core_clk);
    chk_bits("irq raised", 5'h01, {4'h0, irq});
    axi_rd(`PCG_OFF_INT_STAT, d, r);
    chk_word("status", 32'h3, d);
    @(negedge core_clk);
    chk_bits("irq cleared", 5'h00, {4'h0, irq});
    axi_wr(`PCG_OFF_INT_MASK, 32'h0, 4'hf, r);
    probe(PCG_P_CMP0, 1'b0, 1'b1);
    repeat (2) @(negedge core_clk);
    chk_bits("irq masked", 5'h00, {4'h0, irq});
    axi_rd(`PCG_OFF_INT_STAT, d, r);
    chk_word("masked status", 32'h1, d);
    axi_rd(`PCG_OFF_INT_STAT, d, r);
    chk_word("status after clear", 32'h0, d);
    axi_wr(12'h0fc, 32'hffff_ffff, 4'hf, r);
    chk_word("unmapped bresp", {30'h0, `PCG_RESP_SLVERR}, {30'h0, r});
    axi_rd(12'h0fc, d, r);
    chk_word("unmapped rresp", {30'h0, `PCG_RESP_SLVERR}, {30'h0, r});
    chk_word("unmapped data", 32'h0, d);
    set_mode(PCG_MODE_DEEP, 5'h0a, 2'h0);
    axi_wr(`PCG_OFF_RUN_CFG, 32'hffff_ffff, 4'hf, r);
    axi_rd(`PCG_OFF_RUN_CFG, d, r);
    chk_word("run config", 32'h0800_0000, d);
    set_mode(PCG_MODE_DEEP, 5'h14, 2'h1);
    set_mode(PCG_MODE_SLEEP, 5'h00, 2'h0);
    set_mode(PCG_MODE_RUN, 5'h0a, 2'h0);
    do_reset();
    check_cold();
    final_report();
  end
endmodule

bind pcg_top pcg_top_properties #(.ADDR_W(ADDR_W), .MAX_ADC_CODE(MAX_ADC_CODE)) u_props (
  .core_clk, .reset_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .periph_req, .periph_resp, .periph_clk_en, .adc_rate_sel, .irq);
